// ---- cpd_cal_pulse.sv ----
// calibration pulse generator with reference delay loop, apb control
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpd_defines.svh"

// each delay element is one clock stage, standing in for the analog buffers:
// the tap sets the return cycle of the request, the bias that of the reference.
// the loop settles where the reference return meets the check pulse edge.
// latency from request to step is set by the first usable tap; the nominal
// tap spacing only survives as a one-clock spread after rounding up.
// limitation: taps 0 and 1 land on one clock, taps 2 to 7 on the next, so
// finer tap steps cannot be seen at this clock rate.

module cpd_cal_pulse #(
   parameter int AW = 8
) (
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [AW-1:0] paddr,
   input  wire logic [31:0]   pwdata,
   output var  logic [31:0]   prdata,
   output var  logic          pready,
   output var  logic          pslverr,
   // calibration step outputs
   output var  logic          step_drive_out,
   output var  logic          step_drive_out_n,
   output var  logic [7:0]    cal_lines,
   // loop observation
   output var  logic          ref_check_pulse,
   output var  logic          charge_cmd,
   output var  logic          discharge_cmd,
   output var  logic [3:0]    bias_level,
   output var  logic          ref_line_testpoint,
   output var  logic          signal_line_testpoint
);

   // tap index width for the sixteen-element lines; both lines share it so
   // the reference and signal paths stay matched stage for stage
   localparam int LW = $clog2(`CPD_LINE_ELEMENTS);

   cpd_pkg::cpd_state_t s_q;
   cpd_pkg::cpd_state_t s_d;

   logic          tap_valid;
   logic [2:0]    tap_idx;
   logic          active;
   logic          req_rise;
   logic          sig_in;
   logic          sig_ret;
   logic          ref_in;
   logic          ref_ret;
   logic [LW-1:0] sig_tap;
   logic [LW-1:0] ref_tap;

   // lowest-numbered low select line wins; none low means no tap
   // a scan from the top down lets the lowest line overwrite the others
   function automatic logic [3:0] lowest_low(input logic [7:0] sel_n);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (!sel_n[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   // cycles from request edge to return for a tap, rounded up to whole clocks
   // rounding up keeps the step from ever landing before its nominal time
   function automatic logic [3:0] tap_delay_cycles(input logic [2:0] idx);
      int ps;
      ps = `CPD_STEP_BASE_PS + `CPD_TAP0_OFFSET_PS + `CPD_TAP_STEP_PS * int'(idx);
      return 4'((ps + `CPD_CLK_PERIOD_PS - 1) / `CPD_CLK_PERIOD_PS);
   endfunction

   // address match against an eight-bit register offset
   function automatic logic addr_is(input logic [AW-1:0] a, input logic [7:0] off);
      return a == AW'(off);
   endfunction

   // control word read back in the layout that software writes
   function automatic logic [31:0] ctrl_word(input cpd_pkg::cpd_ctrl_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`CPD_CTRL_TAP_LSB +: 8]  = c.tap_sel_n;
      w[`CPD_CTRL_SHUTDOWN]      = c.shutdown;
      w[`CPD_CTRL_CLEAR]         = c.chip_clear;
      w[`CPD_CTRL_REQ]           = c.cal_req;
      w[`CPD_CTRL_LINE_LSB +: 8] = c.line_en;
      return w;
   endfunction

   // status word as software sees it
   // unused bits read as zero so software can mask without surprises
   function automatic logic [31:0] status_word(input cpd_pkg::cpd_state_t s,
                                                input logic v, input logic [2:0] idx);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`CPD_STAT_STEP]                         = s.step;
      w[`CPD_STAT_TOGGLE]                       = s.toggle;
      w[`CPD_STAT_TAP_VALID]                    = v;
      w[`CPD_STAT_TAP_LSB +: 3]                 = idx;
      w[`CPD_STAT_BIAS_LSB +: 4]                = s.bias;
      w[`CPD_STAT_SHUTDOWN]                     = s.ctrl.shutdown;
      w[`CPD_STAT_EVENTS_LSB +: 16]             = s.events;
      return w;
   endfunction

   // tap decode and line drive terms
   // these terms read only registered state, so the lines see clean inputs
   always_comb begin
      {tap_valid, tap_idx} = lowest_low(s_q.ctrl.tap_sel_n);
      active   = !s_q.ctrl.shutdown && !s_q.ctrl.chip_clear;
      req_rise = s_q.ctrl.cal_req && !s_q.req_prev;
      // an edge with no tap selected is dropped rather than guessing a delay
      sig_in   = active && req_rise && tap_valid;
      // only the central eight elements may be tapped
      sig_tap  = LW'(`CPD_TAP_FIRST) + LW'(tap_delay_cycles(tap_idx)) - LW'(1);
      // launch window is the first pulse-width of each eight-clock round
      ref_in   = active && (32'(s_q.seq_cnt) < 32'(`CPD_PULSE_CYCLES));
      ref_tap  = LW'(s_q.bias);
   end

   // signal line carries the request edge to the selected tap
   // clearing the lines on shutdown or clear drops a pending step; a late
   // step after software has moved on would be worse than a lost one
   cpd_delay_line #(
      .DEPTH (`CPD_LINE_ELEMENTS)
   ) u_signal_line (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (!active),
      .line_in (sig_in),
      .tap     (sig_tap),
      .tap_out (sig_ret)
   );

   // reference line is matched to the signal line and trimmed by the bias
   cpd_delay_line #(
      .DEPTH (`CPD_LINE_ELEMENTS)
   ) u_reference_line (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (!active),
      .line_in (ref_in),
      .tap     (ref_tap),
      .tap_out (ref_ret)
   );

   // next state: bus, calibration path, sequencer and phase detector
   always_comb begin
      logic ret_rise;
      logic chk_rise;
      ret_rise = 1'b0;
      chk_rise = 1'b0;
      s_d = s_q;

      // apb: answer one cycle after setup so read data comes from a flop
      // the pready term in the setup test keeps a held setup from answering twice
      // reads sample state in setup, one clock before the access edge
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel && !penable && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !(addr_is(paddr, `CPD_CTRL_OFFSET) ||
                         (addr_is(paddr, `CPD_STATUS_OFFSET) && !pwrite));
         if (addr_is(paddr, `CPD_CTRL_OFFSET)) begin
            s_d.prdata = ctrl_word(s_q.ctrl);
         end else if (addr_is(paddr, `CPD_STATUS_OFFSET)) begin
            s_d.prdata = status_word(s_q, tap_valid, tap_idx);
         end else begin
            s_d.prdata = 32'h0000_0000;
         end
      end
      // write lands on the access edge; status is read-only, so a write there errs
      if (psel && penable && s_q.pready && pwrite && addr_is(paddr, `CPD_CTRL_OFFSET)) begin
         s_d.ctrl.tap_sel_n  = pwdata[`CPD_CTRL_TAP_LSB +: 8];
         s_d.ctrl.shutdown   = pwdata[`CPD_CTRL_SHUTDOWN];
         s_d.ctrl.chip_clear = pwdata[`CPD_CTRL_CLEAR];
         s_d.ctrl.cal_req    = pwdata[`CPD_CTRL_REQ];
         s_d.ctrl.line_en    = pwdata[`CPD_CTRL_LINE_LSB +: 8];
      end

      // request edge detect keeps running so a held request fires only once
      s_d.req_prev = s_q.ctrl.cal_req;

      if (s_q.ctrl.chip_clear) begin
         // clear returns loop and polarity to their power-up values
         // tested before shutdown, so clear still recovers a frozen loop
         s_d.toggle    = 1'b0;
         s_d.step      = 1'b0;
         s_d.seq_cnt   = 3'h0;
         s_d.chk       = 1'b0;
         s_d.chk_prev  = 1'b0;
         s_d.ret_prev  = 1'b0;
         s_d.pd        = cpd_pkg::CPD_PD_ARMED;
         s_d.bias      = `CPD_BIAS_RST;
         s_d.charge    = 1'b0;
         s_d.discharge = 1'b0;
         s_d.events    = 16'h0000;
      end else if (s_q.ctrl.shutdown) begin
         // shutdown freezes polarity and bias, parks the sequencer
         // bias is kept so the loop relocks at once when shutdown ends
         s_d.seq_cnt   = 3'h0;
         s_d.chk       = 1'b0;
         s_d.chk_prev  = 1'b0;
         s_d.ret_prev  = 1'b0;
         s_d.pd        = cpd_pkg::CPD_PD_ARMED;
         s_d.charge    = 1'b0;
         s_d.discharge = 1'b0;
      end else begin
         // calibration path: request edge flips polarity, return loads the step
         // the toggle flips a whole tap delay ahead of the return, so the
         // step always loads the polarity of its own request
         if (sig_in) begin
            s_d.toggle = !s_q.toggle;
            s_d.events = s_q.events + 16'h0001;
         end
         if (sig_ret) begin
            s_d.step = s_q.toggle;
         end

         // sequencer: free-running eight-clock round, independent of requests
         // the round wraps by counter width; the check pulse trails the launch
         // by two clocks and lasts as many clocks as the launch pulse
         s_d.seq_cnt = s_q.seq_cnt + 3'h1;
         s_d.chk = (32'(s_q.seq_cnt) >= 32'(`CPD_CHECK_DELAY)) &&
                   (32'(s_q.seq_cnt) < 32'(`CPD_CHECK_DELAY + `CPD_PULSE_CYCLES));
         s_d.chk_prev = s_q.chk;
         s_d.ret_prev = ref_ret;

         // phase detector: the first edge of the round decides the command
         // later edges in the same round are ignored until it rearms
         // a tie leaves bias alone, which is where the loop settles
         // bias saturates at both ends so a stuck line cannot wrap the trim
         chk_rise = s_q.chk && !s_q.chk_prev;
         ret_rise = ref_ret && !s_q.ret_prev;
         s_d.charge    = 1'b0;
         s_d.discharge = 1'b0;
         if (s_q.seq_cnt == 3'h0) begin
            s_d.pd = cpd_pkg::CPD_PD_ARMED;
         end
         unique case (s_q.pd)
            cpd_pkg::CPD_PD_ARMED: begin
               if (ret_rise || chk_rise) begin
                  s_d.pd = cpd_pkg::CPD_PD_DONE;
               end
               // return early means a short line: charge to slow it down
               if (ret_rise && !chk_rise) begin
                  s_d.charge = 1'b1;
                  if (s_q.bias != `CPD_BIAS_MAX) begin
                     s_d.bias = s_q.bias + 4'h1;
                  end
               end else if (chk_rise && !ret_rise) begin
                  s_d.discharge = 1'b1;
                  if (s_q.bias != `CPD_BIAS_MIN) begin
                     s_d.bias = s_q.bias - 4'h1;
                  end
               end
            end
            cpd_pkg::CPD_PD_DONE: begin
               s_d.pd = (s_q.seq_cnt == 3'h7) ? cpd_pkg::CPD_PD_ARMED : cpd_pkg::CPD_PD_DONE;
            end
         endcase
      end

      // registered copies for the pins
      // step copies are built from the next state so pins and state move on the same edge; testpoints register the current returns
      s_d.step_n  = !s_d.step;
      s_d.cal_out = s_d.ctrl.line_en & {8{s_d.step}};
      s_d.ref_tp  = ref_ret && active;
      s_d.sig_tp  = sig_ret && active;
   end

   // single state register; asynchronous reset loads constants only
   // fields not named below come up zero, the sequencer count included
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q                <= '0;
         s_q.ctrl.tap_sel_n <= `CPD_TAP_SEL_RST;
         s_q.ctrl.line_en   <= `CPD_LINE_EN_RST;
         s_q.step_n         <= 1'b1;
         s_q.bias           <= `CPD_BIAS_RST;
         s_q.pd             <= cpd_pkg::CPD_PD_ARMED;
      end else begin
         s_q <= s_d;
      end
   end

   // pins straight from the state register
   // no logic between flop and pin keeps output timing free of decode paths
   assign prdata                = s_q.prdata;
   assign pready                = s_q.pready;
   assign pslverr               = s_q.pslverr;
   assign step_drive_out        = s_q.step;
   assign step_drive_out_n      = s_q.step_n;
   assign cal_lines             = s_q.cal_out;
   assign ref_check_pulse       = s_q.chk;
   assign charge_cmd            = s_q.charge;
   assign discharge_cmd         = s_q.discharge;
   assign bias_level            = s_q.bias;
   assign ref_line_testpoint    = s_q.ref_tp;
   assign signal_line_testpoint = s_q.sig_tp;

endmodule // cpd_cal_pulse

`default_nettype wire

// ---- cpd_cal_pulse_bench.sv ----
// self-checking bench for the calibration pulse delay loop
`timescale 1ns/1ps
`default_nettype none
module cpd_cal_pulse_bench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, err, pol;
   logic        step_drive_out, step_drive_out_n, ref_check_pulse, charge_cmd;
   logic        discharge_cmd, ref_line_testpoint, signal_line_testpoint;
   logic [7:0]  paddr, cal_lines;
   logic [3:0]  bias_level;
   logic [31:0] pwdata, prdata, rd;
   bit          ok;
   int          n_errors = 0;
   int          checks_done = 0;
   int          ev = 0;
   int          base = -1;
   // 50 MHz clock
   always #10 pclk = ~pclk;
   // design and the control model facing it
   cpd_cal_pulse cpd_cal_pulse_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .step_drive_out, .step_drive_out_n, .cal_lines,
      .ref_check_pulse, .charge_cmd, .discharge_cmd, .bias_level, .ref_line_testpoint,
      .signal_line_testpoint);
   cpd_ctl_model cpd_ctl_model_inst (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr);
   task automatic results();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus transfer; a hung slave ends the run
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      cpd_ctl_model_inst.xfer(w, a, d, rd, err, ok);
      if (!ok) begin
         n_errors++;
         results();
      end
   endtask
   // counts high cycles of check pulse and reference return over two sequencer rounds
   task automatic hi(output int c, output int r);
      c = 0;
      r = 0;
      repeat (16) begin
         @(posedge pclk);
         if (ref_check_pulse === 1'b1) c++;
         if (ref_line_testpoint === 1'b1) r++;
      end
   endtask
   // one event; step timing kept relative to tap 0, so only the tap spread is judged
   task automatic fire(input logic [7:0] sel, input int d, input logic [2:0] idx);
      int n;
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(sel, 3'b000));
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(sel, 3'b100));
      pol = !pol;
      ev++;
      n = 0;
      while (step_drive_out !== pol && n < 12) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 12) begin
         n_errors++;
         results();
      end
      if (base < 0) base = n - d;
      cmp("step delay", 32'(base + d), 32'(n));
      cmp("step pair", {30'h0, pol, !pol}, {30'h0, step_drive_out, step_drive_out_n});
      repeat (2) @(posedge pclk);
      cmp("lines", pol ? 32'h5a : 32'h0, {24'h0, cal_lines});
      acc(1'b0, 8'h04, 32'h0);
      cmp("status", {ev[15:0], 9'h000, idx, 1'b0, 1'b1, pol, pol}, rd & 32'hffff1077);
   endtask
   task automatic t_taps();
      for (int k = 0; k < 8; k++) fire(8'(~(8'h01 << k)), k < 2 ? 1 : 2, 3'(k));
      fire(8'h00, 1, 3'd0);
      fire(8'hf3, 2, 3'd2);
   endtask
   // held request and an empty tap select must both leave the step alone
   task automatic t_hold();
      repeat (10) @(posedge pclk);
      cmp("held", {31'h0, pol}, {31'h0, step_drive_out});
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hff, 3'b000));
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hff, 3'b100));
      repeat (8) @(posedge pclk);
      acc(1'b0, 8'h04, 32'h0);
      cmp("no tap", {ev[15:0], 14'h0, pol, pol}, rd & 32'hffff0003);
   endtask
   task automatic t_shut();
      int c;
      int r;
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hfe, 3'b001));
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hfe, 3'b101));
      repeat (8) @(posedge pclk);
      hi(c, r);
      cmp("pulses off", 32'h0, 32'(c));
      cmp("returns off", 32'h0, 32'(r));
      cmp("step off", {31'h0, pol}, {31'h0, step_drive_out});
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hfe, 3'b000));
      repeat (8) @(posedge pclk);
      hi(c, r);
      cmp("pulses on", 32'h6, 32'(c));
      cmp("ref returns", 32'h6, 32'(r));
      cmp("bias lock", 32'h2, {28'h0, bias_level});
   endtask
   task automatic t_clear();
      fire(8'hfd, 1, 3'd1);
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hfe, 3'b010));
      acc(1'b1, 8'h00, cpd_ctl_model_inst.ctl(8'hfe, 3'b000));
      pol = 1'b0;
      ev = 0;
      acc(1'b0, 8'h04, 32'h0);
      cmp("cleared", 32'h4, rd & 32'hffff1077);
      fire(8'hfe, 1, 3'd0);
      cmp("bias relock", 32'h2, {28'h0, bias_level});
   endtask
   // main sequence
   initial begin
      pol = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      acc(1'b0, 8'h00, 32'h0);
      cmp("ctrl reset", 32'hfe, rd);
      acc(1'b0, 8'h04, 32'h0);
      cmp("status reset", 32'h4, rd & 32'hffff1077);
      acc(1'b0, 8'h08, 32'h0);
      cmp("unmapped", 32'h1, {31'h0, err});
      t_taps();
      t_hold();
      t_shut();
      t_clear();
      results();
   end
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      results();
   end
endmodule // cpd_cal_pulse_bench
`default_nettype wire

// ---- cpd_cal_pulse_chk.sv ----
// port checker for the calibration pulse delay loop
`timescale 1ns/1ps
`default_nettype none
`include "cpd_defines.svh"
module cpd_cal_pulse_chk #(
   parameter int AW = 8
) (
   // clock, reset and bus
   input wire logic          pclk,
   input wire logic          presetn,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic          pready,
   // watched outputs
   input wire logic          step_drive_out,
   input wire logic          step_drive_out_n,
   input wire logic          ref_check_pulse,
   input wire logic          charge_cmd,
   input wire logic          discharge_cmd,
   input wire logic [3:0]    bias_level,
   input wire logic          signal_line_testpoint
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic       sd_q;
   logic       clr_q;
   logic [2:0] off_q;
   logic [3:0] calm_q;
   // shadow of shutdown and clear; calm counts cycles free of both,
   // because the sequencer restarts its phase after either
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_q <= 1'b0;
         clr_q <= 1'b0;
         off_q <= 3'h0;
         calm_q <= 4'h0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == `CPD_CTRL_OFFSET) begin
            sd_q <= pwdata[`CPD_CTRL_SHUTDOWN];
            clr_q <= pwdata[`CPD_CTRL_CLEAR];
         end
         off_q <= !sd_q ? 3'h0 : (off_q == 3'h7 ? off_q : off_q + 3'h1);
         calm_q <= (sd_q || clr_q) ? 4'h0 : (calm_q == 4'hf ? calm_q : calm_q + 4'h1);
      end
   end
   step_pair_a: assert property (step_drive_out_n == !step_drive_out)
      else $error("step outputs not complementary");
   check_width_a: assert property ($rose(ref_check_pulse) && calm_q == 4'hf |->
      (ref_check_pulse || calm_q != 4'hf) [*3] ##1 !ref_check_pulse)
      else $error("check pulse width wrong");
   seq_period_a: assert property ($rose(ref_check_pulse) && calm_q == 4'hf |->
      ##8 ($rose(ref_check_pulse) || calm_q != 4'hf))
      else $error("sequencer period wrong");
   off_quiet_a: assert property (off_q == 3'h7 |-> !ref_check_pulse && !charge_cmd
      && !discharge_cmd && !signal_line_testpoint && $stable(step_drive_out))
      else $error("activity during shutdown");
   pd_excl_a: assert property (!(charge_cmd && discharge_cmd))
      else $error("charge and discharge together");
   bias_up_a: assert property (charge_cmd |->
      ##[0:1] (bias_level == $past(bias_level) + 4'h1 || bias_level == 4'hf))
      else $error("charge did not raise bias");
   bias_down_a: assert property (discharge_cmd |->
      ##[0:1] (bias_level == $past(bias_level) - 4'h1 || bias_level == 4'h1))
      else $error("discharge did not lower bias");
   step_cause_a: assert property ($changed(step_drive_out) |-> signal_line_testpoint
      || $past(signal_line_testpoint) || clr_q || $past(clr_q))
      else $error("step moved without line return");
endmodule // cpd_cal_pulse_chk
bind cpd_cal_pulse cpd_cal_pulse_chk #(.AW(AW)) cpd_cal_pulse_chk_inst (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .step_drive_out, .step_drive_out_n,
   .ref_check_pulse, .charge_cmd, .discharge_cmd, .bias_level, .signal_line_testpoint);
`default_nettype wire

// ---- cpd_ctl_model.sv ----
// apb master model standing in for the on-chip control logic
`timescale 1ns/1ps
`default_nettype none
module cpd_ctl_model (
   // clock
   input  wire logic        pclk,
   // apb master side
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [7:0]  paddr,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // bus idle from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // control word: bits are {request, clear, shutdown}, lines 1,3,4,6 enabled
   function automatic logic [31:0] ctl(input logic [7:0] sel_n, input logic [2:0] bits);
      return {16'h005a, 5'h00, bits, sel_n};
   endfunction
   // setup then access, held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output bit ok);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      ok = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // cpd_ctl_model
`default_nettype wire

// ---- cpd_defines.svh ----
// constants for the calibration pulse delay loop: offsets, fields, reset values, timing
//
// Contract
// - with several select lines low, only the lowest-numbered one counts
// - tap 0 offset is -9.75ns, each higher tap adds 3.25ns, tap 7 +13.0ns
// - step outputs change 25ns plus tap offset after request rising edge; here 6 clocks, 120ns, for taps 0-1, 7 clocks, 140ns, for taps 2-7
// - step direction reverses on every successive calibrate request
// - request edge and returning edge clock a toggle and a registered step output
// - sequencer launches one 50ns pulse into reference line every 8 clocks; here the pulse is rounded up to 3 clocks, 60ns
// - two clocks after each launch a second 50ns pulse goes to the phase detector; here it is 3 clocks, 60ns
// - phase detector compares check pulse and reference return, commands charge or discharge
// - reference timing runs while shutdown is low, without disturbing calibration outputs
// - shutdown high stops all activity including reference line sequencing
// - signal line tappable at central eight of sixteen elements, tap feeds return; here the eight taps reach only elements 4 and 5
// - logic runs on the system clock; full line length equals two clock periods; here each of the 16 elements is one clock, 16 clocks in all
// - an active-high reset returns the logic to its initial state; here the reset is presetn, active low
`ifndef CPD_DEFINES_SVH
`define CPD_DEFINES_SVH

// register byte offsets
`define CPD_CTRL_OFFSET      8'h00
`define CPD_STATUS_OFFSET    8'h04

// control register fields
`define CPD_CTRL_TAP_LSB     0
`define CPD_CTRL_SHUTDOWN    8
`define CPD_CTRL_CLEAR       9
`define CPD_CTRL_REQ         10
`define CPD_CTRL_LINE_LSB    16
`define CPD_TAP_SEL_RST      8'hfe
`define CPD_LINE_EN_RST      8'h00

// status register fields
`define CPD_STAT_STEP        0
`define CPD_STAT_TOGGLE      1
`define CPD_STAT_TAP_VALID   2
`define CPD_STAT_TAP_LSB     4
`define CPD_STAT_BIAS_LSB    8
`define CPD_STAT_SHUTDOWN    12
`define CPD_STAT_EVENTS_LSB  16

// timing, in picoseconds as printed, and derived cycle counts
`define CPD_CLK_PERIOD_PS    20000
`define CPD_STEP_BASE_PS     25000
`define CPD_TAP0_OFFSET_PS   (-9750)
`define CPD_TAP_STEP_PS      3250
`define CPD_PULSE_PS         50000
`define CPD_PULSE_CYCLES     ((`CPD_PULSE_PS + `CPD_CLK_PERIOD_PS - 1) / `CPD_CLK_PERIOD_PS)
`define CPD_SEQ_PERIOD       8
`define CPD_CHECK_DELAY      2
`define CPD_LINE_CYCLES      2
`define CPD_LINE_ELEMENTS    16
`define CPD_TAP_FIRST        4
`define CPD_BIAS_RST         4'h4
`define CPD_BIAS_MIN         4'h1
`define CPD_BIAS_MAX         4'hf

`endif

// ---- cpd_delay_line.sv ----
// tapped delay line model: one shift stage per clock, tap picks the return point
`timescale 1ns/1ps
`default_nettype none

module cpd_delay_line #(
   parameter int DEPTH = 16,
   parameter int IW    = $clog2(DEPTH)
) (
   // clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          clear,
   // line
   input  wire logic          line_in,
   input  wire logic [IW-1:0] tap,
   output var  logic          tap_out
);

   typedef struct packed {
      logic [DEPTH-1:0] sr;
   } cpd_line_state_t;

   cpd_line_state_t s_q;
   cpd_line_state_t s_d;

   // shift the pulse one element per clock; clear empties the line at once
   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d.sr = '0;
      end else begin
         s_d.sr = {s_q.sr[DEPTH-2:0], line_in};
      end
      tap_out = s_q.sr[tap];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule // cpd_delay_line

`default_nettype wire

// ---- cpd_pkg.sv ----
// types for the calibration pulse delay loop
`include "cpd_defines.svh"

package cpd_pkg;

   // phase detector: armed until the first of the two edges decides
   typedef enum logic [0:0] {
      CPD_PD_ARMED = 1'b0,
      CPD_PD_DONE  = 1'b1
   } cpd_pd_e_t;

   // software control fields
   typedef struct packed {
      logic [7:0] line_en;
      logic       cal_req;
      logic       chip_clear;
      logic       shutdown;
      logic [7:0] tap_sel_n;
   } cpd_ctrl_t;

   // whole state of the top module
   typedef struct packed {
      cpd_ctrl_t  ctrl;
      logic       pready;
      logic       pslverr;
      logic [31:0] prdata;
      logic       req_prev;
      logic       toggle;
      logic       step;
      logic       step_n;
      logic [7:0] cal_out;
      logic [2:0] seq_cnt;
      logic       chk;
      logic       chk_prev;
      logic       ret_prev;
      cpd_pd_e_t  pd;
      logic [3:0] bias;
      logic       charge;
      logic       discharge;
      logic       ref_tp;
      logic       sig_tp;
      logic [15:0] events;
   } cpd_state_t;

endpackage
